// >>> rtl/mdg_pkg.sv
package mdg_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  // Byte offsets of the register map
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_PARAM1   = 8'h04;
  localparam logic [7:0]  OFF_PARAM2   = 8'h08;
  localparam logic [7:0]  OFF_BUFLEN   = 8'h0C;
  localparam logic [7:0]  OFF_BUFADDR  = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;
  localparam logic [7:0]  OFF_RESPLEN  = 8'h18;
  localparam logic [7:0]  OFF_MODEM    = 8'h1C;
  // Command codes
  localparam logic [7:0]  CMD_TX       = 8'h20;
  localparam logic [7:0]  CMD_RX       = 8'h30;
  // Control and status register fields
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_CMD_LSB = 8;
  localparam int          STAT_DONE    = 1;
  // First parameter fields
  localparam int          P1_NEW_LSB   = 0;
  localparam int          NEW_W        = 5;
  localparam int          P1_CHANGE    = 7;
  localparam int          P1_CHECK     = 8;
  localparam int          P1_REQ_LSB   = 9;
  localparam int          REQ_W        = 7;
  localparam int          P1_MASK_EN   = 16;
  localparam int          P1_MASK_LSB  = 17;
  // Second parameter field
  localparam int          P2_TMO_LSB   = 0;
  localparam int          TMO_W        = 16;
  localparam int          LEN_W        = 16;
  // Result codes in the status register
  localparam logic [3:0]  RES_NONE     = 4'h0;
  localparam logic [3:0]  RES_OK       = 4'h1;
  localparam logic [3:0]  RES_TIMEOUT  = 4'h2;
  localparam logic [3:0]  RES_ERROR    = 4'h3;
  localparam logic [3:0]  RES_BADCMD   = 4'h4;
  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [4:0]  RST_MODEM    = 5'h00;
  // Timeout step
  localparam int          STEP_MS      = 10;
  localparam int          CLK_NS       = 8;
  localparam int          STEP_CYC     = (STEP_MS * 1000000) / CLK_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_XFER} mdg_state_t;
endpackage

// >>> rtl/mdg_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mdg_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport eng (output run, input tick);
endinterface
`default_nettype wire

// >>> rtl/mdg_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module mdg_tick_gen #(
  parameter int STEP_CYC = mdg_pkg::STEP_CYC
) (
  input  wire logic clk,
  input  wire logic reset_n,
  mdg_tick_if.gen   tk
);
  typedef struct packed
  {
    logic [31:0] cnt;
    logic        tick;
  } mdg_tick_state_t;

  mdg_tick_state_t s_r;
  mdg_tick_state_t s_nxt;

  // Restart on every new wait so the first step is a full step
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!tk.run)
    begin
      s_nxt.cnt = 32'h0;
    end
    else if (s_r.cnt == 32'(STEP_CYC - 1))
    begin
      s_nxt.cnt  = 32'h0;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tk.tick = s_r.tick;
endmodule
`default_nettype wire

// >>> rtl/mdg_cmd_engine.sv
// What this block does
// - Check required status before transmitting
// - Status bits 9..15 map to incoming circuits
// - Receive also waits on required status
// - Bits 23:16 mask the required status
// - Bit 16 clear: condition met at once
// - Mask bits 17..23 qualify bits 9..15
// - Wait bounded by 16-bit 10 ms timeout
// - Timeout abandons wait, reports timeout
// - Zero timeout waits forever; upper unused
// - Receive answers only at end or error
// - Bits 4:0 drive outgoing modem circuits
// - Bit 7 gates the outgoing update
// - Bit 8 gates the status wait
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mdg_cmd_engine #(
  parameter int STEP_CYC = mdg_pkg::STEP_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [4:0]  modemOut,
  input  wire logic [6:0]  modemIn,
  output var  logic        xferReq,
  output var  logic        xferRx,
  output var  logic [31:0] xferAddr,
  output var  logic [31:0] xferLen,
  input  wire logic        xferDone,
  input  wire logic        xferErr,
  input  wire logic [15:0] xferCount
);
  typedef struct packed
  {
    mdg_pkg::mdg_state_t st;
    logic [7:0]          cmd;
    logic [31:0]         p1;
    logic [31:0]         p2;
    logic [31:0]         bufLen;
    logic [31:0]         bufAddr;
    logic [15:0]         tmo;
    logic                tmoOn;
    logic [4:0]          mOut;
    logic                busy;
    logic                done;
    logic [3:0]          res;
    logic [15:0]         rlen;
    logic                xReq;
    logic [31:0]         rdata;
    logic                slvErr;
  } mdg_eng_state_t;

  mdg_eng_state_t s_r;
  mdg_eng_state_t s_nxt;
  mdg_tick_if     tk ();

  mdg_tick_gen #(
    .STEP_CYC (STEP_CYC)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tk      (tk)
  );

  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      mdg_pkg::OFF_CTRL,
      mdg_pkg::OFF_PARAM1,
      mdg_pkg::OFF_PARAM2,
      mdg_pkg::OFF_BUFLEN,
      mdg_pkg::OFF_BUFADDR,
      mdg_pkg::OFF_STATUS,
      mdg_pkg::OFF_RESPLEN,
      mdg_pkg::OFF_MODEM: isMapped = 1'b1;
      default:            isMapped = 1'b0;
    endcase
  endfunction

  // Any other code ends at once with a bad-command result
  function automatic logic validCmd(input logic [7:0] c);
    validCmd = (c == mdg_pkg::CMD_TX) || (c == mdg_pkg::CMD_RX);
  endfunction

  // Bit n of modemIn is the circuit that required-status bit 9+n names
  function automatic logic statusMet(input logic [31:0] p,
                                     input logic [6:0]  lines);
    logic [6:0] req;
    logic [6:0] msk;
    req = p[mdg_pkg::P1_REQ_LSB +: mdg_pkg::REQ_W];
    msk = p[mdg_pkg::P1_MASK_LSB +: mdg_pkg::REQ_W];
    if (!p[mdg_pkg::P1_MASK_EN])
      statusMet = 1'b1;
    else
      statusMet = ((req ^ lines) & msk) == 7'h00;
  endfunction

  function automatic logic [31:0] readWord(input mdg_eng_state_t s,
                                           input logic [7:0]     a,
                                           input logic [6:0]     lines);
    case (a)
      mdg_pkg::OFF_CTRL:
      begin
        readWord = {16'h0000, s.cmd, 7'h00, s.busy};
      end
      mdg_pkg::OFF_PARAM1:
      begin
        readWord = s.p1;
      end
      mdg_pkg::OFF_PARAM2:
      begin
        readWord = s.p2;
      end
      mdg_pkg::OFF_BUFLEN:
      begin
        readWord = s.bufLen;
      end
      mdg_pkg::OFF_BUFADDR:
      begin
        readWord = s.bufAddr;
      end
      mdg_pkg::OFF_STATUS:
      begin
        // The wait flag shows the live state, not a snapshot
        readWord = {24'h000000, s.res, 1'b0,
                    s.st == mdg_pkg::ST_WAIT, s.done, s.busy};
      end
      mdg_pkg::OFF_RESPLEN:
      begin
        readWord = {16'h0000, s.rlen};
      end
      mdg_pkg::OFF_MODEM:
      begin
        readWord = {16'h0000, lines, 4'h0, s.mOut};
      end
      default:
      begin
        readWord = 32'h0000_0000;
      end
    endcase
  endfunction

  logic setupPh;
  logic wrAcc;
  logic startReq;
  logic doneSet;
  logic doneClr;

  assign setupPh = psel && !penable;
  assign wrAcc   = psel && penable && pwrite;

  always_comb
  begin
    s_nxt    = s_r;
    doneSet  = 1'b0;
    startReq = 1'b0;
    doneClr  = 1'b0;

    // Read data is captured in the setup cycle so it leaves a flip-flop
    if (setupPh)
    begin
      s_nxt.rdata  = readWord(s_r, paddr, modemIn);
      s_nxt.slvErr = !isMapped(paddr);
    end

    if (wrAcc)
    begin
      case (paddr)
        mdg_pkg::OFF_CTRL:
        begin
          startReq = pwdata[mdg_pkg::CTRL_START] && !s_r.busy;
        end
        // Parameters are frozen while a command runs
        mdg_pkg::OFF_PARAM1:
        begin
          if (!s_r.busy)
          begin
            s_nxt.p1 = pwdata;
          end
        end
        mdg_pkg::OFF_PARAM2:
        begin
          if (!s_r.busy)
          begin
            s_nxt.p2 = pwdata;
          end
        end
        mdg_pkg::OFF_BUFLEN:
        begin
          if (!s_r.busy)
          begin
            s_nxt.bufLen = pwdata;
          end
        end
        mdg_pkg::OFF_BUFADDR:
        begin
          if (!s_r.busy)
          begin
            s_nxt.bufAddr = pwdata;
          end
        end
        mdg_pkg::OFF_STATUS:
        begin
          doneClr = pwdata[mdg_pkg::STAT_DONE];
        end
        mdg_pkg::OFF_MODEM:
        begin
          if (!s_r.busy)
          begin
            s_nxt.mOut = pwdata[mdg_pkg::P1_NEW_LSB +: mdg_pkg::NEW_W];
          end
        end
        default:
        begin
          s_nxt.st = s_r.st;
        end
      endcase
    end

    case (s_r.st)
      mdg_pkg::ST_IDLE:
      begin
        if (startReq)
        begin
          s_nxt.cmd = pwdata[mdg_pkg::CTRL_CMD_LSB +: 8];
          if (!validCmd(s_nxt.cmd))
          begin
            s_nxt.res = mdg_pkg::RES_BADCMD;
            doneSet   = 1'b1;
          end
          else
          begin
            s_nxt.busy = 1'b1;
            s_nxt.res  = mdg_pkg::RES_NONE;
            if (s_r.p1[mdg_pkg::P1_CHANGE])
            begin
              s_nxt.mOut = s_r.p1[mdg_pkg::P1_NEW_LSB +: mdg_pkg::NEW_W];
            end
            if (s_r.p1[mdg_pkg::P1_CHECK])
            begin
              // Both directions hold off the same way
              s_nxt.st    = mdg_pkg::ST_WAIT;
              s_nxt.tmo   = s_r.p2[mdg_pkg::P2_TMO_LSB +: mdg_pkg::TMO_W];
              s_nxt.tmoOn = s_nxt.tmo != 16'h0000;
            end
            else
            begin
              s_nxt.st   = mdg_pkg::ST_XFER;
              s_nxt.xReq = 1'b1;
            end
          end
        end
      end
      mdg_pkg::ST_WAIT:
      begin
        if (statusMet(s_r.p1, modemIn))
        begin
          s_nxt.st   = mdg_pkg::ST_XFER;
          s_nxt.xReq = 1'b1;
        end
        else if (s_r.tmoOn && tk.tick)
        begin
          s_nxt.tmo = s_r.tmo - 16'h0001;
          if (s_r.tmo == 16'h0001)
          begin
            // Expiry ends the command with no data moved
            s_nxt.st   = mdg_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.res  = mdg_pkg::RES_TIMEOUT;
            s_nxt.rlen = 16'h0000;
            doneSet    = 1'b1;
          end
        end
      end
      mdg_pkg::ST_XFER:
      begin
        // Response waits for the data mover, never earlier
        if (xferDone)
        begin
          s_nxt.st   = mdg_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.xReq = 1'b0;
          s_nxt.res  = xferErr ? mdg_pkg::RES_ERROR : mdg_pkg::RES_OK;
          s_nxt.rlen = (s_r.cmd == mdg_pkg::CMD_RX) ? xferCount
                                                     : s_r.bufLen[15:0];
          doneSet    = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st   = mdg_pkg::ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.xReq = 1'b0;
      end
    endcase

    // A completion in the clearing cycle must not be lost
    s_nxt.done = doneSet || (s_r.done && !doneClr);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r         <= '0;
      s_r.st      <= mdg_pkg::ST_IDLE;
      s_r.p1      <= mdg_pkg::RST_WORD;
      s_r.p2      <= mdg_pkg::RST_WORD;
      s_r.mOut    <= mdg_pkg::RST_MODEM;
      s_r.res     <= mdg_pkg::RES_NONE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign tk.run = (s_r.st == mdg_pkg::ST_WAIT) && s_r.tmoOn;

  // Zero-wait slave: every access phase completes at once
  assign pready   = 1'b1;
  assign prdata   = s_r.rdata;
  assign pslverr  = s_r.slvErr;
  assign modemOut = s_r.mOut;
  assign xferReq  = s_r.xReq;
  assign xferRx   = s_r.cmd == mdg_pkg::CMD_RX;
  assign xferAddr = s_r.bufAddr;
  assign xferLen  = s_r.bufLen;
endmodule
`default_nettype wire

// >>> tb/mdg_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mdg_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [4:0]  modemOut,
  input wire logic [6:0]  modemIn,
  input wire logic        xferReq,
  input wire logic [31:0] xferLen,
  input wire logic        xferDone
);
  // Shadow of the first parameter; the bench only writes it while idle
  logic [31:0] param1_r;
  logic        start;
  assign start = psel && penable && pwrite && paddr == mdg_pkg::OFF_CTRL && pwdata[0]
    && (pwdata[15:8] == mdg_pkg::CMD_TX || pwdata[15:8] == mdg_pkg::CMD_RX);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      param1_r <= 32'h0;
    else if (psel && penable && pwrite && paddr == mdg_pkg::OFF_PARAM1)
      param1_r <= pwdata;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_end;
    xferReq && xferDone;
  endsequence
  sequence s_busy2;
    xferReq ##1 xferReq;
  endsequence
  property p_drop;
    s_end |=> !xferReq;
  endproperty
  property p_hold;
    xferReq && !xferDone |=> xferReq;
  endproperty
  property p_len;
    s_busy2 |-> $stable(xferLen);
  endproperty
  property p_keep;
    s_busy2 |-> $stable(modemOut);
  endproperty
  property p_apply;
    start |=> modemOut == (param1_r[7] ? param1_r[4:0] : $past(modemOut));
  endproperty
  property p_direct;
    start && !param1_r[8] |=> xferReq;
  endproperty
  property p_nomask;
    start && param1_r[8] && !param1_r[16] |-> ##2 xferReq;
  endproperty
  property p_match;
    $rose(xferReq) && param1_r[8] && param1_r[16]
      |-> ((param1_r[15:9] ^ $past(modemIn)) & param1_r[23:17]) == 7'h00;
  endproperty
  a_drop: assert property (p_drop)
    else $error("request held after done");
  a_hold: assert property (p_hold)
    else $error("request dropped early");
  a_len: assert property (p_len)
    else $error("length moved while busy");
  a_keep: assert property (p_keep)
    else $error("modem out moved while busy");
  a_apply: assert property (p_apply)
    else $error("modem out wrong after start");
  a_direct: assert property (p_direct)
    else $error("no request without check");
  a_nomask: assert property (p_nomask)
    else $error("no request with mask off");
  a_match: assert property (p_match)
    else $error("request without match");
endmodule
bind mdg_cmd_engine mdg_asserts u_mdg_asserts (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .modemOut, .modemIn, .xferReq, .xferLen, .xferDone);
`default_nettype wire

// >>> tb/mdg_modem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mdg_modem_model (
  input  wire logic        clk,
  input  wire logic [6:0]  lineLevel,
  input  wire logic        xferReq,
  input  wire logic [7:0]  lag,
  input  wire logic        fail,
  input  wire logic [15:0] rxBytes,
  output var  logic [6:0]  modemIn = 7'h00,
  output var  logic        xferDone = 1'b0,
  output var  logic        xferErr = 1'b0,
  output var  logic [15:0] xferCount = 16'h0000
);
  logic [7:0] cnt = 8'h00;
  // Result lines carry junk outside the done pulse
  always @(posedge clk)
  begin
    modemIn <= lineLevel;
    xferDone <= 1'b0;
    xferErr <= ~fail;
    xferCount <= ~rxBytes;
    cnt <= (xferReq && !xferDone) ? cnt + 8'h01 : 8'h00;
    if (xferReq && !xferDone && cnt == lag)
    begin
      xferDone <= 1'b1;
      xferErr <= fail;
      xferCount <= rxBytes;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  modemOut;
  logic [6:0]  modemIn;
  logic        xferReq;
  logic        xferRx;
  logic [31:0] xferAddr;
  logic [31:0] xferLen;
  logic        xferDone;
  logic        xferErr;
  logic [15:0] xferCount;
  logic [6:0]  lineLevel = 7'h00;
  logic [7:0]  lag = 8'h05;
  logic        fail = 1'b0;
  logic [15:0] rxBytes = 16'h0123;
  logic [31:0] q;
  logic        slvErr;
  int          fails = 0;
  int          nTests = 0;
  int          cyc = 0;
  mdg_cmd_engine #(.STEP_CYC(4)) u_mdg_cmd_engine (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .modemOut, .modemIn, .xferReq, .xferRx,
    .xferAddr, .xferLen, .xferDone, .xferErr, .xferCount);
  mdg_modem_model u_mdg_modem_model (.clk, .lineLevel, .xferReq, .lag, .fail, .rxBytes,
    .modemIn, .xferDone, .xferErr, .xferCount);
  always #4 clk = ~clk;
  task automatic report_and_stop();
    $display("tests %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard: far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [7:0] c, input logic [31:0] p1, input logic [31:0] p2);
    apb(1'b1, mdg_pkg::OFF_PARAM1, p1);
    apb(1'b1, mdg_pkg::OFF_PARAM2, p2);
    apb(1'b1, mdg_pkg::OFF_BUFLEN, 32'h0000_0040);
    apb(1'b1, mdg_pkg::OFF_BUFADDR, 32'h0000_1000);
    apb(1'b1, mdg_pkg::OFF_CTRL, {16'h0000, c, 8'h01});
    #1;
  endtask
  task automatic fin(input logic [3:0] r, input logic [31:0] len);
    do apb(1'b0, mdg_pkg::OFF_STATUS, 32'h0); while (q[0] !== 1'b0);
    chk({28'h0, q[7:4]}, {28'h0, r});
    apb(1'b0, mdg_pkg::OFF_RESPLEN, 32'h0);
    chk(q, len);
  endtask
  task automatic t_rx();
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, slvErr}, 32'h1);
    go(mdg_pkg::CMD_RX, 32'h0000_0095, 32'h0);
    chk({26'h0, xferRx, modemOut}, {26'h0, 1'b1, 5'h15});
    chk({31'h0, xferReq}, 32'h1);
    chk(xferAddr, 32'h0000_1000);
    chk(xferLen, 32'h0000_0040);
    fin(mdg_pkg::RES_OK, 32'h0123);
  endtask
  task automatic t_map();
    logic [31:0] p;
    for (int i = 0; i < 7; i++)
    begin
      p = (32'h0002_0000 << i) | (32'h0000_0200 << i) | 32'h0001_0100;
      lineLevel <= 7'h7F ^ (7'h01 << i);
      go(mdg_pkg::CMD_TX, p, 32'h1);
      fin(mdg_pkg::RES_TIMEOUT, 32'h0);
      lineLevel <= 7'h01 << i;
      go(mdg_pkg::CMD_TX, p, 32'h1);
      fin(mdg_pkg::RES_OK, 32'h0040);
    end
  endtask
  task automatic t_wait();
    lineLevel <= 7'h77;
    go(mdg_pkg::CMD_RX, 32'h0011_1100, 32'h0);
    repeat (50) @(posedge clk);
    chk({31'h0, xferReq}, 32'h0);
    lineLevel <= 7'h7F;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, xferReq}, 32'h1);
    fin(mdg_pkg::RES_OK, 32'h0123);
    lineLevel <= 7'h00;
    go(mdg_pkg::CMD_TX, 32'h0011_1100, 32'h3);
    repeat (7) @(posedge clk);
    apb(1'b0, mdg_pkg::OFF_STATUS, 32'h0);
    chk({30'h0, q[2], q[0]}, 32'h3);
    fin(mdg_pkg::RES_TIMEOUT, 32'h0);
    chk({27'h0, modemOut}, 32'h15);
    fail <= 1'b1;
    go(mdg_pkg::CMD_TX, 32'h00FE_FF00, 32'h0);
    fin(mdg_pkg::RES_ERROR, 32'h0040);
    go(8'h40, 32'h0, 32'h0);
    fin(mdg_pkg::RES_BADCMD, 32'h0040);
    apb(1'b1, mdg_pkg::OFF_STATUS, 32'h2);
    apb(1'b0, mdg_pkg::OFF_STATUS, 32'h0);
    chk({30'h0, q[1:0]}, 32'h0);
    apb(1'b1, mdg_pkg::OFF_MODEM, 32'h0A);
    apb(1'b0, mdg_pkg::OFF_MODEM, 32'h0);
    chk(q, {16'h0, lineLevel, 9'h00A});
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_rx();
    t_map();
    t_wait();
    report_and_stop();
  end
endmodule
`default_nettype wire
